// ==== logic/stdc_pkg.sv ====
package stdc_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses within the block)
  // ---------------------------------------------------------------
  localparam logic [31:0] STDC_BASE_ADDR = 32'hE000E000;
  localparam logic [11:0] STDC_OFF_CTRL = 12'h010;
  localparam logic [11:0] STDC_OFF_RELOAD = 12'h014;
  localparam logic [11:0] STDC_OFF_CURRENT = 12'h018;
  localparam logic [11:0] STDC_OFF_CALIB = 12'h01C;
  localparam logic [11:0] STDC_OFF_IRQ_STATUS = 12'h020;
  localparam logic [11:0] STDC_OFF_IRQ_MASK = 12'h024;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STDC_BIT_ENABLE = 0;
  localparam int STDC_BIT_EXC_EN = 1;
  localparam int STDC_BIT_SRC = 2;
  localparam int STDC_BIT_WRAP = 16;
  localparam int STDC_BIT_NO_REFERENCE_FLAG = 31;
  localparam int STDC_BIT_INEXACT = 30;
  localparam int STDC_CNT_W = 24;

  // ---------------------------------------------------------------
  // reset and fixed values
  // ---------------------------------------------------------------
  localparam logic [2:0] STDC_CTRL_RST = 3'h0;
  localparam logic [23:0] STDC_COUNT_RST = 24'h000000;
  localparam logic [23:0] STDC_TEN_MS_CAL = 24'h0009C4;
  localparam logic STDC_NO_REFERENCE_FLAG_VAL = 1'b0;
  localparam logic STDC_INEXACT_VAL = 1'b0;
  localparam logic [1:0] STDC_IRQ_RST = 2'h0;

  // ---------------------------------------------------------------
  // timing: reference tick is the oscillator divided by 32
  // ---------------------------------------------------------------
  localparam int STDC_REF_DIV = 32;
  localparam logic [4:0] STDC_REF_DIV_LAST = 5'(STDC_REF_DIV - 1);

  // control bits carried together
  typedef struct packed {
    logic src_sel;
    logic exc_en;
    logic enable;
  } stdc_ctrl_t;

endpackage

// ==== logic/stdc_tick_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bit 16 flags a zero since last read
// - any control/status read clears wrap flag
// - bit 2 picks cpu clock or ref/32
// - bit 1 lets wrap pend tick exception
// - enable loads reload and runs; 0 stops
// - 24-bit reload copied on zero; upper zero
// - reference tick is oscillator divided by 32
// - registers at base plus 0x10 to 0x24
// - control bits zero at reset; reserved zero
// - current write clears counter and wrap flag
// - calibration reports 10 ms value and flags
module stdc_tick_timer
  import stdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk_in,
  output logic tick_pend,
  output logic irq
);

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  stdc_ctrl_t ctrl_ff, nxt_ctrl;         // enable, exception enable, source
  logic wrap_ff, nxt_wrap;               // sticky wrap flag
  logic [23:0] reload_ff, nxt_reload;    // reload value
  logic [23:0] count_ff, nxt_count;      // current value
  logic [1:0] ists_ff, nxt_ists;         // irq status: 0 wrap, 1 ref-tick missing unused
  logic [1:0] imask_ff, nxt_imask;       // irq mask
  logic tick_pend_ff, nxt_tick_pend;     // one-cycle exception pend
  logic [31:0] prdata_ff, nxt_prdata;    // registered read data
  logic [1:0] osc_sync_ff;               // pin synchroniser
  logic osc_prev_ff;                     // previous synced level
  logic [4:0] div_ff, nxt_div;           // divide-by-32 counter
  logic ref_tick_ff, nxt_ref_tick;       // reference tick pulse

  // ---------------------------------------------------------------
  // bus decode helpers
  // ---------------------------------------------------------------
  // match full address against one register
  function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
    hit = (a == (STDC_BASE_ADDR | {20'h00000, off}));
  endfunction

  logic acc;        // access phase
  logic wr_acc;     // write taking effect
  logic rd_acc;     // read taking effect
  logic rd_setup;   // read in setup phase, data captured here
  logic mapped;     // address is a register
  logic sel_ctrl, sel_rel, sel_cur, sel_cal, sel_ist, sel_imk;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    acc = psel && penable;
    wr_acc = acc && pwrite;
    rd_acc = acc && !pwrite;
    rd_setup = psel && !penable && !pwrite;
    sel_ctrl = hit(paddr, STDC_OFF_CTRL);
    sel_rel = hit(paddr, STDC_OFF_RELOAD);
    sel_cur = hit(paddr, STDC_OFF_CURRENT);
    sel_cal = hit(paddr, STDC_OFF_CALIB);
    sel_ist = hit(paddr, STDC_OFF_IRQ_STATUS);
    sel_imk = hit(paddr, STDC_OFF_IRQ_MASK);
    mapped = sel_ctrl || sel_rel || sel_cur || sel_cal || sel_ist || sel_imk;
  end

  // always ready; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;
  assign tick_pend = tick_pend_ff;
  // level interrupt from unmasked sticky bits
  assign irq = |(ists_ff & imask_ff);

  // ---------------------------------------------------------------
  // reference tick generation
  // ---------------------------------------------------------------
  // synchroniser on the selected oscillator pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_ff <= 2'h0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[0], osc_clk_in};
      osc_prev_ff <= osc_sync_ff[1];
    end
  end

  // count oscillator rising edges, pulse every 32nd
  always_comb begin
    nxt_div = div_ff;
    nxt_ref_tick = 1'b0;
    if (osc_sync_ff[1] && !osc_prev_ff) begin
      if (div_ff == STDC_REF_DIV_LAST) begin
        nxt_div = 5'h00;
        nxt_ref_tick = 1'b1;
      end else begin
        nxt_div = div_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 5'h00;
      ref_tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ref_tick_ff <= nxt_ref_tick;
    end
  end

  // ---------------------------------------------------------------
  // counter, control and flags
  // ---------------------------------------------------------------
  logic tick;       // selected count tick
  logic wrap_evt;   // counter reloads from zero this cycle

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_wrap = wrap_ff;
    nxt_reload = reload_ff;
    nxt_count = count_ff;
    nxt_ists = ists_ff;
    nxt_imask = imask_ff;
    nxt_tick_pend = 1'b0;
    // cpu clock ticks every cycle, else reference tick
    tick = ctrl_ff.src_sel ? 1'b1 : ref_tick_ff;
    wrap_evt = ctrl_ff.enable && tick && (count_ff == STDC_COUNT_RST);

    if (ctrl_ff.enable && tick) begin
      if (count_ff == STDC_COUNT_RST) begin
        nxt_count = reload_ff;
      end else begin
        nxt_count = count_ff - 24'h000001;
      end
    end

    if (rd_acc && sel_ctrl) begin
      nxt_wrap = 1'b0;
    end
    // write to current value clears both
    if (wr_acc && sel_cur) begin
      nxt_count = STDC_COUNT_RST;
      nxt_wrap = 1'b0;
    end
    // wrap sets flag, winning over clear
    if (wrap_evt) begin
      nxt_wrap = 1'b1;
      nxt_ists[0] = 1'b1;
      nxt_tick_pend = ctrl_ff.exc_en;
    end

    if (wr_acc) begin
      if (sel_ctrl) begin
        nxt_ctrl.enable = pwdata[STDC_BIT_ENABLE];
        nxt_ctrl.exc_en = pwdata[STDC_BIT_EXC_EN];
        nxt_ctrl.src_sel = pwdata[STDC_BIT_SRC];
        if (pwdata[STDC_BIT_ENABLE] && !ctrl_ff.enable) begin
          nxt_count = reload_ff;
        end
      end else if (sel_rel) begin
        nxt_reload = pwdata[23:0];
      end else if (sel_ist) begin
        // write one to clear, a fresh wrap wins
        nxt_ists = (ists_ff & ~pwdata[1:0]) | {1'b0, wrap_evt};
      end else if (sel_imk) begin
        nxt_imask = pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= STDC_CTRL_RST;
      wrap_ff <= 1'b0;
      reload_ff <= STDC_COUNT_RST;
      count_ff <= STDC_COUNT_RST;
      ists_ff <= STDC_IRQ_RST;
      imask_ff <= STDC_IRQ_RST;
      tick_pend_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      wrap_ff <= nxt_wrap;
      reload_ff <= nxt_reload;
      count_ff <= nxt_count;
      ists_ff <= nxt_ists;
      imask_ff <= nxt_imask;
      tick_pend_ff <= nxt_tick_pend;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // captured at the setup edge so the word stands through the access
  // cycle, in which pready is already high
  always_comb begin
    nxt_prdata = 32'h00000000;
    if (rd_setup) begin
      if (sel_ctrl) begin
        // reserved bits read zero
        // a wrap in the setup cycle is reported, not lost to the clear
        nxt_prdata[STDC_BIT_WRAP] = wrap_ff || wrap_evt;
        nxt_prdata[STDC_BIT_SRC] = ctrl_ff.src_sel;
        nxt_prdata[STDC_BIT_EXC_EN] = ctrl_ff.exc_en;
        nxt_prdata[STDC_BIT_ENABLE] = ctrl_ff.enable;
      end else if (sel_rel) begin
        nxt_prdata = {8'h00, reload_ff};
      end else if (sel_cur) begin
        nxt_prdata = {8'h00, count_ff};
      end else if (sel_cal) begin
        nxt_prdata = {STDC_NO_REFERENCE_FLAG_VAL, STDC_INEXACT_VAL, 6'h00, STDC_TEN_MS_CAL};
      end else if (sel_ist) begin
        nxt_prdata = {30'h00000000, ists_ff};
      end else if (sel_imk) begin
        nxt_prdata = {30'h00000000, imask_ff};
      end
    end
  end

  // read data is registered: valid during the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // reference tick spacing monitor
  // ---------------------------------------------------------------
  logic [5:0] ref_gap_ff, nxt_ref_gap;   // cycles since last reference tick

  always_comb begin
    nxt_ref_gap = ref_gap_ff;
    if (ref_tick_ff) begin
      // tick seen: start counting again
      nxt_ref_gap = 6'h00;
    end else if (ref_gap_ff != 6'h3F) begin
      // still below the top, saturate there
      nxt_ref_gap = ref_gap_ff + 6'h01;
    end
  end

  // only read by the spacing check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_gap_ff <= 6'h3F;
    end else begin
      ref_gap_ff <= nxt_ref_gap;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrap_sets_flag: assert property (wrap_evt |=> wrap_ff)
    else $error("wrap flag not set after wrap");
  // read clears flag absent a wrap
  a_read_clears_flag: assert property (rd_acc && sel_ctrl && !wrap_evt |=> !wrap_ff)
    else $error("read did not clear wrap flag");
  a_pend_needs_enable: assert property (tick_pend |-> $past(ctrl_ff.exc_en))
    else $error("pend without exception enable");
  a_stop_holds_count: assert property (
    !ctrl_ff.enable && !(wr_acc && (sel_ctrl || sel_cur)) |=> $stable(count_ff))
    else $error("counter moved while stopped");
  a_zero_reloads: assert property (
    wrap_evt && !(wr_acc && (sel_cur || sel_ctrl)) |=> count_ff == $past(reload_ff))
    else $error("no reload at zero");
  // no reference tick right after another
  a_ref_spacing: assert property (ref_tick_ff |=> !ref_tick_ff [*8])
    else $error("reference tick too frequent");
  a_cur_write_clears: assert property (
    wr_acc && sel_cur |=> count_ff == STDC_COUNT_RST && (wrap_ff == $past(wrap_evt)))
    else $error("current write did not clear");
  a_cpu_decrement: assert property (
    ctrl_ff.enable && ctrl_ff.src_sel && count_ff != STDC_COUNT_RST && !wr_acc
    |=> count_ff == $past(count_ff) - 24'h000001)
    else $error("no decrement on cpu clock");
  // reserved control bits zero while read data stands
  a_reserved_zero: assert property (
    rd_acc && sel_ctrl |-> prdata[31:17] == 15'h0000 && prdata[15:3] == 13'h0000)
    else $error("reserved bits nonzero");
  // reference ticks at least 32 cycles apart
  a_ref_gap: assert property (ref_tick_ff |-> ref_gap_ff >= {1'b0, STDC_REF_DIV_LAST})
    else $error("reference ticks too close");
  a_enable_loads: assert property (
    wr_acc && sel_ctrl && pwdata[STDC_BIT_ENABLE] && !ctrl_ff.enable
    |=> count_ff == $past(reload_ff))
    else $error("enable did not load reload value");
  // wrap with exception enabled
  sequence s_wrap_pending;
    wrap_evt && ctrl_ff.exc_en;
  endsequence
  a_pend_on_wrap: assert property (s_wrap_pending |=> tick_pend)
    else $error("enabled wrap did not pend");
  a_status_sets: assert property (wrap_evt |=> ists_ff[0])
    else $error("wrap did not set status");
  // calibration word while read data stands
  a_calib_word: assert property (
    rd_acc && sel_cal |-> prdata[23:0] == STDC_TEN_MS_CAL && prdata[29:24] == 6'h00)
    else $error("calibration word wrong");
  // reload and current upper bits zero
  a_upper_zero: assert property (
    rd_acc && (sel_rel || sel_cur) |-> prdata[31:24] == 8'h00)
    else $error("upper value bits nonzero");

endmodule

`default_nettype wire

// ==== verif/tb_system_tick_down_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_system_tick_down_counter
  import stdc_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0; // active low reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, rd2;
  logic pready, pslverr, tick_pend, irq, err;
  logic osc_clk_in = 1'b0, osc_run = 1'b0; // oscillator pin and its gate
  logic [1:0] osc_div = 2'h0; // oscillator period of four pclk
  int n_mismatch = 0, compares = 0, cyc;

  always #10 pclk = ~pclk;

  // oscillator toggles only while gated on
  always @(posedge pclk) begin
    if (osc_run) begin
      osc_div <= osc_div + 2'h1;
      osc_clk_in <= osc_div[1];
    end
  end

  stdc_tick_timer i_stdc_tick_timer (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_clk_in(osc_clk_in),
    .tick_pend(tick_pend),
    .irq(irq)
  );

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ---------------------------------------------------------------
  // apb transfer: setup, access until pready, then one idle cycle
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd);
    int n;
    n = 0;
    // setup phase, launched just after an edge
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= STDC_BASE_ADDR + 32'(off);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // bounded wait on the slave answer, sampled at the edge
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge pclk);
    end
    // answer taken at the completing edge, then released
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input string what, input logic [11:0] off, input logic [31:0] exp);
    bus(1'b0, off, 32'h0);
    chk(what, exp, rd);
  endtask

  // cycles until next exception pulse, 0 when none within lim
  task automatic watch(input int lim, output int c);
    c = 0;
    for (int n = 1; n <= lim && c == 0; n++) begin
      @(posedge pclk);
      if (tick_pend === 1'b1) begin
        c = n;
      end
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl reset", STDC_OFF_CTRL, 32'h0);
    rdchk("calib", STDC_OFF_CALIB, 32'h000009C4);
    rdchk("mask reset", STDC_OFF_IRQ_MASK, 32'h0);
    bus(1'b1, STDC_OFF_RELOAD, 32'hFFFFFFFF);
    rdchk("reload width", STDC_OFF_RELOAD, 32'h00FFFFFF);
    bus(1'b1, STDC_OFF_CALIB, 32'h0);
    rdchk("calib read only", STDC_OFF_CALIB, 32'h000009C4);
    bus(1'b0, 12'h040, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // cpu clock source: load, then one step per pclk
    bus(1'b1, STDC_OFF_RELOAD, 32'h00000100);
    bus(1'b1, STDC_OFF_CTRL, 32'h00000005);
    bus(1'b0, STDC_OFF_CURRENT, 32'h0);
    rd2 = rd;
    chk("loaded", 32'h1, {31'h0, rd2 <= 32'h100 && rd2 >= 32'hF8});
    bus(1'b0, STDC_OFF_CURRENT, 32'h0);
    chk("step", 32'h3, rd2 - rd);
    bus(1'b1, STDC_OFF_CTRL, 32'h00000004);
    bus(1'b0, STDC_OFF_CURRENT, 32'h0);
    rd2 = rd;
    rdchk("stopped", STDC_OFF_CURRENT, rd2);
    // exception only when its enable is set
    bus(1'b1, STDC_OFF_RELOAD, 32'h00000005);
    bus(1'b1, STDC_OFF_CTRL, 32'h00000005);
    watch(40, cyc);
    chk("no pend", 32'h0, 32'(cyc));
    bus(1'b1, STDC_OFF_CTRL, 32'h00000007);
    watch(40, cyc);
    watch(40, cyc);
    chk("period", 32'h6, 32'(cyc));
    rdchk("wrap flag", STDC_OFF_CTRL, 32'h00010007);
    bus(1'b1, STDC_OFF_CTRL, 32'h0);
    bus(1'b0, STDC_OFF_CTRL, 32'h0);
    rdchk("flag cleared", STDC_OFF_CTRL, 32'h0);
    // current write clears count and flag
    bus(1'b1, STDC_OFF_CTRL, 32'h00000005);
    repeat (20) @(posedge pclk);
    bus(1'b1, STDC_OFF_CTRL, 32'h0);
    bus(1'b1, STDC_OFF_CURRENT, 32'h0000ABCD);
    rdchk("current clear", STDC_OFF_CURRENT, 32'h0);
    rdchk("flag by current", STDC_OFF_CTRL, 32'h0);
    // interrupt status, mask and clear
    rdchk("irq status", STDC_OFF_IRQ_STATUS, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, STDC_OFF_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, STDC_OFF_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk("status cleared", STDC_OFF_IRQ_STATUS, 32'h0);
    // reference source: idle without oscillator, 32 edges per step
    bus(1'b1, STDC_OFF_RELOAD, 32'h00000001);
    bus(1'b1, STDC_OFF_CTRL, 32'h00000003);
    watch(300, cyc);
    chk("ref idle", 32'h0, 32'(cyc));
    osc_run <= 1'b1;
    watch(1000, cyc);
    watch(1000, cyc);
    chk("ref period", 32'h00000100, 32'(cyc));
    // second reset with the timer running and the flag set
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl after reset", STDC_OFF_CTRL, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
